// ### design/fabric_pkg.sv
/*
 shared constants and types of the macrocell fabric: geometry, special
 product terms, configuration word layout and the register map.
 assumes: every file names these through fabric_pkg:: and nothing imports it.
*/
package fabric_pkg;
	// geometry
	localparam int BLOCKS        = 4;
	localparam int MACROCELLS    = 16;
	localparam int BANK_SIZE     = 8;
	localparam int BLOCK_INPUTS  = 26;
	localparam int ALL_TERMS     = 70;
	localparam int CLUSTER_TERMS = 4;
	localparam int SRC_COUNT     = 134;
	// special product terms
	localparam int PT_OE         = 64;
	localparam int PT_RESET      = 68;
	localparam int PT_PRESET     = 69;
	// reset values
	localparam logic [7:0]  ROUTE_RESET = 8'hff;
	localparam logic [25:0] TERM_ERASED = 26'h3ffffff;
	// word offsets inside one block's window
	localparam logic [8:0]  OFS_MC      = 9'h100;
	localparam logic [8:0]  OFS_ROUTE   = 9'h120;
	localparam logic [8:0]  OFS_STEER   = 9'h140;
	// word address layout (word index = HADDR[14:2])
	localparam int WA_HI         = 14;
	localparam int WA_LO         = 2;
	localparam int STATUS_BIT    = 12;
	localparam int GAP_BIT       = 11;
	// status words, index inside the status region, and the HSIZE of a word transfer
	localparam logic [11:0] STAT_PIN_LO = 12'h004;
	localparam logic [11:0] STAT_PIN_HI = 12'h005;
	localparam logic [11:0] STAT_INPUTS = 12'h006;
	localparam logic [2:0]  SIZE_WORD   = 3'h2;

	typedef enum logic [1:0] {OE_OFF, OE_ON, OE_PT0, OE_PT1} oe_mode_t;
	typedef enum logic [1:0] {STEER_OWN, STEER_DOWN, STEER_UP, STEER_NONE} steer_t;

	typedef struct packed {
		oe_mode_t   oe;
		logic [1:0] clk_sel;
		logic       toggle;
		logic       invert;
		logic       registered;
	} mc_cfg_t;

	typedef struct packed {
		logic        en;
		logic [8:0]  ofs;
		logic [31:0] data;
	} cfg_wr_t;
endpackage

// ### design/logic_block.sv
/*
 logic_block: product-term array of one block (64 logic terms and six
 special terms) and the cluster allocator that sums terms per macrocell.
 assumes: writes come from the top's bus slave on the same clock; inputs
 come from the routing matrix and are stable between clock edges.
*/
`timescale 1ns/10ps

module logic_block (
	// system
	input  wire logic                clk,
	input  wire logic                rst_b,
	// configuration access
	input  wire fabric_pkg::cfg_wr_t wr,
	input  wire logic [8:0]          rd_ofs,
	output logic      [31:0]         rd_data,
	// array
	input  wire logic [25:0]         inputs,
	output logic      [15:0]         sum,
	output logic      [3:0]          oe_term,
	output logic                     reset_term,
	output logic                     preset_term
);
	logic [25:0]         true_mask [fabric_pkg::ALL_TERMS];
	logic [25:0]         comp_mask [fabric_pkg::ALL_TERMS];
	fabric_pkg::steer_t  steer     [fabric_pkg::MACROCELLS];
	logic [69:0]         pt;
	logic [15:0]         cluster;

	// a term is the and of its connected literals; erased terms read as 0
	function automatic logic term_on(input logic [25:0] x, input logic [25:0] tm, input logic [25:0] cm);
		return &((~tm | x) & (~cm | ~x));
	endfunction

	function automatic logic feeds(input int c, input fabric_pkg::steer_t s, input int n);
		case (s)
			fabric_pkg::STEER_OWN:  return c == n;
			fabric_pkg::STEER_DOWN: return c - 1 == n;
			fabric_pkg::STEER_UP:   return c + 1 == n;
			default:                return 1'b0;
		endcase
	endfunction

	wire       term_ofs  = ~rd_ofs[8] & (rd_ofs[7:1] < 7'(fabric_pkg::ALL_TERMS));
	wire       steer_ofs = rd_ofs[8:4] == fabric_pkg::OFS_STEER[8:4];
	wire       wr_term   = wr.en & ~wr.ofs[8] & (wr.ofs[7:1] < 7'(fabric_pkg::ALL_TERMS));
	wire       wr_steer  = wr.en & (wr.ofs[8:4] == fabric_pkg::OFS_STEER[8:4]);
	wire [6:0] rd_idx    = rd_ofs[7:1];

	assign rd_data = term_ofs ? {6'h00, rd_ofs[0] ? comp_mask[rd_idx] : true_mask[rd_idx]}
		: steer_ofs ? {30'h0, steer[rd_ofs[3:0]]} : 32'h0;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int t = 0; t < fabric_pkg::ALL_TERMS; t++) begin
				true_mask[t] <= fabric_pkg::TERM_ERASED;
				comp_mask[t] <= fabric_pkg::TERM_ERASED;
			end
			for (int c = 0; c < fabric_pkg::MACROCELLS; c++) begin
				steer[c] <= fabric_pkg::STEER_OWN;
			end
		end else begin
			if (wr_term && wr.ofs[0]) begin
				comp_mask[wr.ofs[7:1]] <= wr.data[25:0];
			end
			if (wr_term && !wr.ofs[0]) begin
				true_mask[wr.ofs[7:1]] <= wr.data[25:0];
			end
			if (wr_steer) begin
				steer[wr.ofs[3:0]] <= fabric_pkg::steer_t'(wr.data[1:0]);
			end
		end
	end

	always_comb begin
		for (int t = 0; t < fabric_pkg::ALL_TERMS; t++) begin
			pt[t] = term_on(inputs, true_mask[t], comp_mask[t]);
		end
		for (int c = 0; c < fabric_pkg::MACROCELLS; c++) begin
			cluster[c] = |pt[c * fabric_pkg::CLUSTER_TERMS +: fabric_pkg::CLUSTER_TERMS];
		end
		// each cluster reaches one neighbour at most, so a cell sums 12 terms at most
		for (int n = 0; n < fabric_pkg::MACROCELLS; n++) begin
			sum[n] = 1'b0;
			for (int c = 0; c < fabric_pkg::MACROCELLS; c++) begin
				sum[n] = sum[n] | (cluster[c] & feeds(c, steer[c], n));
			end
		end
	end

	assign oe_term     = pt[fabric_pkg::PT_OE +: 4];
	assign reset_term  = pt[fabric_pkg::PT_RESET];
	assign preset_term = pt[fabric_pkg::PT_PRESET];
endmodule

// ### design/macrocell_fabric.sv
/*
 macrocell_fabric: top of the sum-of-products fabric. holds the pin
 synchronisers, the routing matrix, the macrocell registers, the i/o
 cells, the four logic blocks and an ahb-lite slave for configuration.
 assumes: MCLK at 100 MHz; every pin is asynchronous to MCLK; the fabric's
 global clocks are pins sampled on MCLK, so their rising edges are events.
*/
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
// Behaviour
// - 64 i/o pins, 2 dedicated inputs and 4 clock-or-input pins feed the matrix.
// - The matrix hands 26 selected signals to each block's term array.
// - Each block returns 16 macrocell and 16 i/o pin feedbacks to the matrix.
// - A block has 64 logic terms plus 4 enable, 1 reset, 1 preset terms.
// - The allocator shares logic terms so one macrocell sums at most 12 terms.
// - Macrocell n takes clusters n-1, n, n+1; the edge cells take two.
// - Each output is registered or combinatorial, with selectable inversion.
// - Every macrocell feeds its output back, registered or combinatorial.
// - Each flip-flop works as a D register or a toggle-on-one T register.
// - Each flip-flop picks one of four global clocks, still usable as inputs.
// - Registers load on the rising edge of their selected clock.
// - The block's reset and preset terms clear or set all its flip-flops at once.
// - Each block's 16 i/o cells form two banks of 8, each with two enable terms.
// - A driver is always on, always off, or follows one of its bank's terms.
`timescale 1ns/10ps

module macrocell_fabric (
	// system
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// i/o pins
	input  wire logic [63:0] IO_IN,
	output logic      [63:0] IO_OUT,
	output logic      [63:0] IO_OE,
	// dedicated and clock-or-input pins
	input  wire logic [1:0]  DED_IN,
	input  wire logic [3:0]  CLK_PIN
);
	// pin synchronisers
	logic [63:0]         io_meta;
	logic [63:0]         io_sync;
	logic [1:0]          ded_meta;
	logic [1:0]          ded_sync;
	logic [3:0]          clk_meta;
	logic [3:0]          clk_sync;
	logic [3:0]          clk_last;
	logic [3:0]          clk_rise;

	// routing matrix
	logic [133:0]        pool;
	logic [7:0]          route     [fabric_pkg::BLOCKS][fabric_pkg::BLOCK_INPUTS];
	logic [25:0]         blk_in    [fabric_pkg::BLOCKS];

	// logic block results
	fabric_pkg::cfg_wr_t blk_wr    [fabric_pkg::BLOCKS];
	logic [31:0]         blk_rd    [fabric_pkg::BLOCKS];
	logic [15:0]         blk_sum   [fabric_pkg::BLOCKS];
	logic [3:0]          blk_oe    [fabric_pkg::BLOCKS];
	logic                blk_reset [fabric_pkg::BLOCKS];
	logic                blk_preset[fabric_pkg::BLOCKS];

	// macrocells and i/o cells
	fabric_pkg::mc_cfg_t mc_cfg    [fabric_pkg::BLOCKS][fabric_pkg::MACROCELLS];
	logic [15:0]         q         [fabric_pkg::BLOCKS];
	logic [15:0]         next_q    [fabric_pkg::BLOCKS];
	logic [15:0]         eff_q     [fabric_pkg::BLOCKS];
	logic [63:0]         next_out;
	logic [63:0]         next_oe;

	// bus data phase
	logic                ph_valid;
	logic                ph_write;
	logic                ph_size_ok;
	logic [12:0]         ph_addr;
	logic [31:0]         stat_word;
	logic [31:0]         read_word;

	// synchronise every pin before the fabric sees it
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			io_meta  <= 64'h0;
			io_sync  <= 64'h0;
			ded_meta <= 2'h0;
			ded_sync <= 2'h0;
			clk_meta <= 4'h0;
			clk_sync <= 4'h0;
			clk_last <= 4'h0;
		end else begin
			io_meta  <= IO_IN;
			io_sync  <= io_meta;
			ded_meta <= DED_IN;
			ded_sync <= ded_meta;
			clk_meta <= CLK_PIN;
			clk_sync <= clk_meta;
			clk_last <= clk_sync;
		end
	end

	// rising edge of each global clock, seen after synchronisation
	assign clk_rise = clk_sync & ~clk_last;

	// source pool: macrocell feedback, pin feedback, dedicated and clock pins
	assign pool = {clk_sync, ded_sync, io_sync, IO_OUT};

	// routing matrix: unrouted or out-of-range selects deliver 0
	always_comb begin
		for (int b = 0; b < fabric_pkg::BLOCKS; b++) begin
			for (int i = 0; i < fabric_pkg::BLOCK_INPUTS; i++) begin
				blk_in[b][i] = (route[b][i] < 8'(fabric_pkg::SRC_COUNT)) ? pool[route[b][i]] : 1'b0;
			end
		end
	end

	// bus address decode of the data phase
	wire       bus_take  = HSEL & HTRANS[1] & HREADY;
	wire       wr_now    = ph_valid & ph_write & ph_size_ok;
	wire       in_status = ph_addr[fabric_pkg::STATUS_BIT];
	wire       in_blocks = ~in_status & ~ph_addr[fabric_pkg::GAP_BIT];
	wire [1:0] ph_blk    = ph_addr[10:9];
	wire [8:0] ph_ofs    = ph_addr[8:0];
	wire [3:0] ph_cell   = ph_addr[3:0];
	wire [4:0] ph_input  = ph_addr[4:0];
	wire [11:0] ph_stat  = ph_addr[11:0];
	wire       hit_mc    = in_blocks & (ph_ofs[8:4] == fabric_pkg::OFS_MC[8:4]);
	wire       hit_route = in_blocks & (ph_ofs[8:5] == fabric_pkg::OFS_ROUTE[8:5])
		& (ph_input < 5'(fabric_pkg::BLOCK_INPUTS));

	// each block sees writes only to its own window
	always_comb begin
		for (int b = 0; b < fabric_pkg::BLOCKS; b++) begin
			blk_wr[b].en   = wr_now & in_blocks & (ph_blk == 2'(b));
			blk_wr[b].ofs  = ph_ofs;
			blk_wr[b].data = HWDATA;
		end
	end

	// status words: register state of each block, then synchronised pins
	assign stat_word = (ph_stat < fabric_pkg::STAT_PIN_LO) ? {16'h0, eff_q[ph_stat[1:0]]}
		: (ph_stat == fabric_pkg::STAT_PIN_LO) ? io_sync[31:0]
		: (ph_stat == fabric_pkg::STAT_PIN_HI) ? io_sync[63:32]
		: (ph_stat == fabric_pkg::STAT_INPUTS) ? {26'h0, clk_sync, ded_sync}
		: 32'h0;

	assign read_word = hit_mc ? {25'h0, mc_cfg[ph_blk][ph_cell]}
		: hit_route ? {24'h0, route[ph_blk][ph_input]}
		: in_blocks ? blk_rd[ph_blk]
		: in_status ? stat_word
		: 32'h0;

	// address phase capture; held through the read wait state
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ph_valid   <= 1'b0;
			ph_write   <= 1'b0;
			ph_size_ok <= 1'b0;
			ph_addr    <= 13'h0;
		end else if (bus_take) begin
			ph_valid   <= 1'b1;
			ph_write   <= HWRITE;
			ph_size_ok <= HSIZE == fabric_pkg::SIZE_WORD;
			ph_addr    <= HADDR[fabric_pkg::WA_HI:fabric_pkg::WA_LO];
		end else if (HREADY) begin
			ph_valid   <= 1'b0;
		end
	end

	// reads take one wait state so a write just before is already stored
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			HREADYOUT <= 1'b1;
			HRDATA    <= 32'h0;
			HRESP     <= 1'b0;
		end else begin
			HRESP <= 1'b0;
			if (ph_valid && !ph_write && !HREADYOUT) begin
				HRDATA    <= read_word;
				HREADYOUT <= 1'b1;
			end else if (bus_take && !HWRITE) begin
				HREADYOUT <= 1'b0;
			end
		end
	end

	// macrocell configuration and routing selects
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int b = 0; b < fabric_pkg::BLOCKS; b++) begin
				for (int n = 0; n < fabric_pkg::MACROCELLS; n++) begin
					mc_cfg[b][n] <= '0;
				end
				for (int i = 0; i < fabric_pkg::BLOCK_INPUTS; i++) begin
					route[b][i] <= fabric_pkg::ROUTE_RESET;
				end
			end
		end else begin
			if (wr_now && hit_mc) begin
				mc_cfg[ph_blk][ph_cell] <= fabric_pkg::mc_cfg_t'(HWDATA[6:0]);
			end
			if (wr_now && hit_route) begin
				route[ph_blk][ph_input] <= HWDATA[7:0];
			end
		end
	end

	// logic blocks
	for (genvar b = 0; b < fabric_pkg::BLOCKS; b++) begin : g_blk
		logic_block u_blk (
			.clk         (MCLK),
			.rst_b       (RST_B),
			.wr          (blk_wr[b]),
			.rd_ofs      (ph_ofs),
			.rd_data     (blk_rd[b]),
			.inputs      (blk_in[b]),
			.sum         (blk_sum[b]),
			.oe_term     (blk_oe[b]),
			.reset_term  (blk_reset[b]),
			.preset_term (blk_preset[b])
		);
	end

	// macrocells and i/o cells
	always_comb begin
		fabric_pkg::mc_cfg_t c;
		logic                 v;
		int                   k;
		c = '0;
		v = 1'b0;
		k = 0;
		for (int b = 0; b < fabric_pkg::BLOCKS; b++) begin
			for (int n = 0; n < fabric_pkg::MACROCELLS; n++) begin
				c = mc_cfg[b][n];
				k = b * fabric_pkg::MACROCELLS + n;
				// reset and preset act on the state at once, without waiting for a clock
				if (blk_reset[b]) begin
					eff_q[b][n]  = 1'b0;
					next_q[b][n] = 1'b0;
				end else if (blk_preset[b]) begin
					eff_q[b][n]  = 1'b1;
					next_q[b][n] = 1'b1;
				end else begin
					eff_q[b][n] = q[b][n];
					if (clk_rise[c.clk_sel]) begin
						next_q[b][n] = c.toggle ? q[b][n] ^ blk_sum[b][n] : blk_sum[b][n];
					end else begin
						next_q[b][n] = q[b][n];
					end
				end
				v = c.registered ? eff_q[b][n] : blk_sum[b][n];
				next_out[k] = v ^ c.invert;
				// bank 0 uses enable terms 0 and 1, bank 1 terms 2 and 3
				case (c.oe)
					fabric_pkg::OE_ON:  next_oe[k] = 1'b1;
					fabric_pkg::OE_PT0: next_oe[k] = blk_oe[b][2 * (n / fabric_pkg::BANK_SIZE)];
					fabric_pkg::OE_PT1: next_oe[k] = blk_oe[b][2 * (n / fabric_pkg::BANK_SIZE) + 1];
					default:            next_oe[k] = 1'b0;
				endcase
			end
		end
	end

	// every flip-flop samples each MCLK edge; clocking is by edge event only
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int b = 0; b < fabric_pkg::BLOCKS; b++) begin
				q[b] <= 16'h0;
			end
			IO_OUT <= 64'h0;
			IO_OE  <= 64'h0;
		end else begin
			for (int b = 0; b < fabric_pkg::BLOCKS; b++) begin
				q[b] <= next_q[b];
			end
			IO_OUT <= next_out;
			IO_OE  <= next_oe;
		end
	end
endmodule

// ### verification/fabric_checker.sv
/* checker: bus timing of the fabric's register slave and its idle pin outputs.
 assumes: bound to macrocell_fabric; one clock; reset low. */
`timescale 1ns/10ps

module fabric_checker (
	// system
	input wire logic        MCLK,
	input wire logic        RST_B,
	// bus
	input wire logic        HSEL,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	// pins
	input wire logic [63:0] IO_OUT,
	input wire logic [63:0] IO_OE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	wire  take = HSEL & HTRANS[1] & HREADY;
	wire  rd_take = take & ~HWRITE;
	logic touched;
	// no configuration written since reset
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			touched <= 1'b0;
		else if (take && HWRITE)
			touched <= 1'b1;
	end
	property p_read_wait;
		rd_take |=> !HREADYOUT ##1 HREADYOUT;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
	property p_write_nowait;
		take && HWRITE |=> HREADYOUT;
	endproperty
	a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
	property p_wait_cause;
		!HREADYOUT |-> $past(rd_take);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("wait state without read");
	property p_wait_one;
		!HREADYOUT |=> HREADYOUT;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state too long");
	property p_okay;
		HRESP == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_rdata_hold;
		HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_oe_quiet;
		!touched |-> IO_OE == 64'h0;
	endproperty
	a_oe_quiet: assert property (p_oe_quiet) else $error("driver on at reset");
	property p_out_quiet;
		!touched |-> IO_OUT == 64'h0;
	endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("output set at reset");
endmodule

bind macrocell_fabric fabric_checker u_chk (
	.MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.IO_OUT(IO_OUT), .IO_OE(IO_OE)
);

// ### verification/pin_board.sv
/* board model: levels on the fabric's i/o pins.
 assumes: the bench sets what the board drives; a pin the fabric drives follows it. */
`timescale 1ns/10ps

module pin_board (
	// fabric side
	input wire logic [63:0] IO_OUT,
	input wire logic [63:0] IO_OE,
	// board side
	input wire logic [63:0] drv,
	input wire logic [63:0] drv_en,
	output logic     [63:0] IO_IN
);
	logic [63:0] last = 64'h0;
	// a pin nobody drives has no pull, so it wanders off its last level
	always @(IO_OUT or IO_OE or drv or drv_en) begin
		for (int k = 0; k < 64; k++) begin
			if (IO_OE[k])
				IO_IN[k] = IO_OUT[k];
			else if (drv_en[k])
				IO_IN[k] = drv[k];
			else
				IO_IN[k] = ~last[k];
			last[k] = IO_IN[k];
		end
	end
endmodule

// ### verification/tb.sv
/* bench of the macrocell fabric: ahb-lite master, board model, checks.
 assumes: design, package and checker compiled first; 100 MHz clock. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("FAIL %s exp %h got %h", n, e, g); end end

module tb;
	logic        MCLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, d, q;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [1:0]  HTRANS, DED_IN;
	logic [2:0]  HSIZE;
	logic [3:0]  CLK_PIN;
	logic [63:0] IO_IN, IO_OUT, IO_OE, drv, drv_en;
	int          err_total, checked, seed, cyc;

	macrocell_fabric dut (.MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
		.DED_IN(DED_IN), .CLK_PIN(CLK_PIN));
	pin_board board (.IO_OUT(IO_OUT), .IO_OE(IO_OE), .drv(drv), .drv_en(drv_en), .IO_IN(IO_IN));

	function automatic logic [31:0] wa(input int b, input int ofs);
		return 32'((b * 32'h200 + ofs) * 4);
	endfunction
	function automatic logic nxt(input logic q0, input logic d0, input logic t);
		return t ? q0 ^ d0 : d0;
	endfunction
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= wr;
		// look at ready half a cycle before the edge that samples it, so no race with its update
		do @(negedge MCLK); while (HREADYOUT !== 1'b1);
		@(posedge MCLK);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(negedge MCLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		@(posedge MCLK);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK("reg", e, rd)
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge MCLK);
	endtask
	task automatic pulse(input int k);
		wt(2);
		CLK_PIN[k] <= 1'b1;
		wt(3);
		CLK_PIN[k] <= 1'b0;
		wt(5);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		{RST_B, HSEL, HWRITE, HADDR, HWDATA, HTRANS, DED_IN, CLK_PIN, drv} = '0;
		HSIZE = 3'h2;
		drv_en = '1;
		seed = 34;
		wt(3);
		RST_B <= 1'b1;
		wt(1);
		drv <= {$random(seed), $random(seed)};
		DED_IN <= 2'h2;
		wt(4);
		rdc(wa(8, 4), drv[31:0]);
		rdc(wa(8, 5), drv[63:32]);
		rdc(wa(8, 6), 32'h2);
		rdc(wa(0, 'h120), 32'hff);
		rdc(wa(1, 'h8b), 32'h3ffffff);
		wr(32'h2000, 32'hffffffff);
		rdc(32'h2000, 32'h0);
		wr(wa(0, 'h120), 32'hffffff80);
		rdc(wa(0, 'h120), 32'h80);
		wr(wa(0, 'h121), 32'h81);
		wr(wa(0, 'h122), 32'h0);
		wr(wa(0, 'h1), 32'h0);
		wr(wa(0, 'h0), 32'h1);
		wr(wa(0, 'h9), 32'h0);
		wr(wa(0, 'h8), 32'h4);
		wr(wa(0, 'h101), 32'h20);
		// combinatorial path with polarity, mirrored by macrocell 1 via feedback
		for (int i = 0; i < 8; i++) begin
			d = 1'($random(seed));
			DED_IN[0] <= d;
			wr(wa(0, 'h100), 32'(32'h20 + (i % 2) * 2));
			wt(6);
			`CHK("comb", d ^ 1'(i % 2), IO_OUT[0])
			`CHK("fb", d ^ 1'(i % 2), IO_OUT[1])
			`CHK("oe_on", 1'b1, IO_OE[0])
		end
		wr(wa(0, 'h100), 32'h20);
		DED_IN[0] <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			wr(wa(0, 'h140), 32'(s));
			wt(6);
			`CHK("steer0", s == 0, IO_OUT[0])
			`CHK("steer1", s == 0 || s == 2, IO_OUT[1])
		end
		wr(wa(0, 'h140), 32'h0);
		wr(wa(0, 'h8b), 32'h0);
		wr(wa(0, 'h8a), 32'h2);
		DED_IN[1] <= 1'b1;
		wt(5);
		rdc(wa(8, 0), 32'hffff);
		rdc(wa(8, 1), 32'h0);
		wr(wa(0, 'h89), 32'h0);
		wr(wa(0, 'h88), 32'h2);
		wt(5);
		rdc(wa(8, 0), 32'h0);
		DED_IN[1] <= 1'b0;
		wt(5);
		rdc(wa(8, 0), 32'h0);
		q = 1'b0;
		// registered: D then T, alternating clock choice
		for (int i = 0; i < 12; i++) begin
			d = 1'($random(seed));
			DED_IN[0] <= d;
			wr(wa(0, 'h100), 32'(32'h21 + (i % 2) * 8 + (i > 5) * 4));
			pulse(1 - i % 2);
			`CHK("hold", q, IO_OUT[0])
			pulse(i % 2);
			q = nxt(q, d, i > 5);
			`CHK("reg_q", q, IO_OUT[0])
		end
		wr(wa(0, 'h81), 32'h0);
		wr(wa(0, 'h80), 32'h1);
		DED_IN[0] <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(wa(0, 'h100), 32'(m * 32));
			wr(wa(0, 'h108), 32'(m * 32));
			wt(6);
			`CHK("oe0", m == 1 || m == 2, IO_OE[0])
			`CHK("oe8", m == 1, IO_OE[8])
		end
		final_report();
	end
endmodule
